// *** bayer_block_statistics.sv ***
// Per-tile Bayer colour statistics with an APB slave and a statistics FIFO.
//
// Overview of operation
// - Incoming pixels are always treated as raw Bayer; RGB or YUV is unsupported.
// - All statistics configuration lives in ctrl_reg_second only.
// - Each frame splits into square tiles, one record per tile.
// - A record holds red, green, blue sums and green_abs_sum.
// - Tile size comes from live_view_res_mode, not from a pixel count.
// - Tiles per row and per column are fixed constants.
// - Programmable skip pixels or lines separate tiles and never enter sums.
// - horiz_skip_count and vert_skip_count are independent fields.
// - Mode 0 with both skips 256 covers a 2560 x 1920 frame.
// - Values are 16 bits, packed two per 32-bit statistics FIFO word.
// - The FIFO is drained by processor reads or DMA transfers.
// - A pixel is taken only on a pixel clock edge with line sync active.
`timescale 1ns/10ps
`default_nettype none
module bayer_block_statistics #(
  parameter int NUM_H = bayer_stat_pkg::NUM_H_TILES,
  parameter int NUM_V = bayer_stat_pkg::NUM_V_TILES,
  parameter int DEPTH = bayer_stat_pkg::FIFO_DEPTH
) (
  // System clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bayer_stat_pkg::ADDR_W-1:0] paddr,
  input wire logic [bayer_stat_pkg::WORD_W-1:0] pwdata,
  output logic [bayer_stat_pkg::WORD_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // DMA request.
  output logic dma_req,
  // Sensor pixel bus.
  input wire logic sensor_pixel_clock,
  input wire logic vsync,
  input wire logic hsync,
  input wire logic [bayer_stat_pkg::PIX_W-1:0] pixel_data
);

  localparam int HIDX_W = $clog2(NUM_H);
  localparam int VW = bayer_stat_pkg::VAL_W;
  localparam int PW = bayer_stat_pkg::POS_W;
  localparam int TW = bayer_stat_pkg::TILE_W;
  localparam int LW = $clog2(DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [VW-1:0] sat_add(input logic [VW-1:0] a,
                                            input logic [bayer_stat_pkg::PIX_W-1:0] b);
    logic [VW:0] s;
    s = {1'b0, a} + {{(VW - bayer_stat_pkg::PIX_W + 1){1'b0}}, b};
    sat_add = s[VW] ? {VW{1'b1}} : s[VW-1:0];
  endfunction

  // Period of one tile step: block plus the decoded skip count.
  function automatic logic [PW-1:0] tile_period(input logic [PW-1:0] blk,
                                                input logic [bayer_stat_pkg::SKIP_W-1:0] f);
    tile_period = blk + {1'b0, f} + 9'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // System clock: registers.

  logic [bayer_stat_pkg::WORD_W-1:0] ctrl_reg_second;
  logic overflow;
  logic setup_phase;
  logic access_done;
  logic rd_popped;
  logic rd_had_data;
  logic [bayer_stat_pkg::ADDR_W-1:0] addr_word;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [bayer_stat_pkg::WORD_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic [bayer_stat_pkg::WORD_W-1:0] fifo_out_data;
  logic [LW-1:0] fifo_level;
  logic [bayer_stat_pkg::WORD_W-1:0] status_word;
  logic push_word;
  logic push_drop;

  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready;
  assign addr_word = {paddr[bayer_stat_pkg::ADDR_W-1:2], 2'b00};
  assign rd_popped = access_done && !pwrite && rd_had_data &&
                     (addr_word == bayer_stat_pkg::OFS_STAT_DATA);

  always_comb begin
    status_word = '0;
    status_word[bayer_stat_pkg::ST_EMPTY_BIT] = !fifo_out_valid;
    status_word[bayer_stat_pkg::ST_FULL_BIT] = !fifo_in_ready;
    status_word[bayer_stat_pkg::ST_OVF_BIT] = overflow;
    status_word[bayer_stat_pkg::ST_LEVEL_LSB +: LW] = fifo_level;
  end

  // The answer is prepared in the setup cycle so pready and prdata both come
  // from flip-flops; every transfer therefore has exactly one access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      rd_had_data <= 1'b0;
    end else if (setup_phase) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= '0;
      rd_had_data <= 1'b0;
      case (addr_word)
        bayer_stat_pkg::OFS_CTRL2: prdata <= ctrl_reg_second;
        bayer_stat_pkg::OFS_STATUS: prdata <= status_word;
        bayer_stat_pkg::OFS_STAT_DATA: begin
          prdata <= fifo_out_valid ? fifo_out_data : '0;
          rd_had_data <= fifo_out_valid;
        end
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg_second <= bayer_stat_pkg::CTRL2_RESET;
    end else if (access_done && pwrite && addr_word == bayer_stat_pkg::OFS_CTRL2) begin
      ctrl_reg_second <= pwdata & bayer_stat_pkg::CTRL2_MASK;
    end
  end

  // A dropped word in the same cycle as a clear keeps the flag set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow <= 1'b0;
    end else if (push_drop) begin
      overflow <= 1'b1;
    end else if (access_done && pwrite && addr_word == bayer_stat_pkg::OFS_STATUS &&
                 pwdata[bayer_stat_pkg::ST_OVF_BIT]) begin
      overflow <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req <= 1'b0;
    end else begin
      dma_req <= fifo_out_valid && !rd_popped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration into the pixel domain.

  // Software should only change the configuration between frames: the fields
  // cross as plain levels and may be seen out of step for one pixel clock.
  logic [bayer_stat_pkg::CFG_W-1:0] cfg_px;
  logic cfg_en;
  logic [bayer_stat_pkg::LIVE_VIEW_RES_MODE_W-1:0] cfg_mode;
  logic [bayer_stat_pkg::SKIP_W-1:0] cfg_hsc;
  logic [bayer_stat_pkg::SKIP_W-1:0] cfg_vsc;

  bayer_stat_sync #(.WIDTH(bayer_stat_pkg::CFG_W)) cfg_sync (
    .clk(sensor_pixel_clock),
    .rst_n(presetn),
    .d({ctrl_reg_second[bayer_stat_pkg::EN_BIT],
        ctrl_reg_second[bayer_stat_pkg::LIVE_VIEW_RES_MODE_LSB +: bayer_stat_pkg::LIVE_VIEW_RES_MODE_W],
        ctrl_reg_second[bayer_stat_pkg::VSC_LSB +: bayer_stat_pkg::SKIP_W],
        ctrl_reg_second[bayer_stat_pkg::HSC_LSB +: bayer_stat_pkg::SKIP_W]}),
    .q(cfg_px)
  );

  assign {cfg_en, cfg_mode, cfg_vsc, cfg_hsc} = cfg_px;

  ////////////////////////////////////////////////////////////////////////////
  // Pixel domain: tile geometry.

  logic hsync_d;
  logic vsync_d;
  logic frame_start;
  logic pix_valid;
  logic line_end;
  logic [PW-1:0] blk;
  logic [PW-1:0] h_period;
  logic [PW-1:0] v_period;
  logic [PW-1:0] hpos;
  logic [PW-1:0] vpos;
  logic [TW-1:0] htile;
  logic [TW-1:0] vtile;
  logic col_par;
  logic row_par;
  logic in_tile;
  logic last_px;

  assign frame_start = vsync && !vsync_d;
  assign pix_valid = hsync && cfg_en;
  assign line_end = hsync_d && !hsync;
  assign blk = bayer_stat_pkg::block_size(cfg_mode);
  assign h_period = tile_period(blk, cfg_hsc);
  assign v_period = tile_period(blk, cfg_vsc);
  assign in_tile = (hpos < blk) && (vpos < blk) &&
                   (htile < NUM_H[TW-1:0]) && (vtile < NUM_V[TW-1:0]);
  assign last_px = pix_valid && in_tile &&
                   (hpos == blk - 9'h001) && (vpos == blk - 9'h001);

  always_ff @(posedge sensor_pixel_clock or negedge presetn) begin
    if (!presetn) begin
      hsync_d <= 1'b0;
      vsync_d <= 1'b0;
    end else begin
      hsync_d <= hsync;
      vsync_d <= vsync;
    end
  end

  always_ff @(posedge sensor_pixel_clock or negedge presetn) begin
    if (!presetn) begin
      hpos <= '0;
      htile <= '0;
      col_par <= 1'b0;
    end else if (frame_start || line_end) begin
      hpos <= '0;
      htile <= '0;
      col_par <= 1'b0;
    end else if (pix_valid) begin
      col_par <= !col_par;
      if (hpos == h_period - 9'h001) begin
        hpos <= '0;
        htile <= htile + 4'h1;
      end else begin
        hpos <= hpos + 9'h001;
      end
    end
  end

  always_ff @(posedge sensor_pixel_clock or negedge presetn) begin
    if (!presetn) begin
      vpos <= '0;
      vtile <= '0;
      row_par <= 1'b0;
    end else if (frame_start) begin
      vpos <= '0;
      vtile <= '0;
      row_par <= 1'b0;
    end else if (line_end) begin
      row_par <= !row_par;
      if (vpos == v_period - 9'h001) begin
        vpos <= '0;
        vtile <= vtile + 4'h1;
      end else begin
        vpos <= vpos + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel domain: accumulation per tile column.

  logic [VW-1:0] acc_r [NUM_H];
  logic [VW-1:0] acc_g [NUM_H];
  logic [VW-1:0] acc_b [NUM_H];
  logic [VW-1:0] acc_a [NUM_H];
  logic [HIDX_W-1:0] hidx;
  logic is_red;
  logic is_blue;
  logic is_green;
  logic [bayer_stat_pkg::PIX_W-1:0] prev_g;
  logic prev_g_ok;
  logic [bayer_stat_pkg::PIX_W-1:0] g_diff;
  logic [VW-1:0] next_r;
  logic [VW-1:0] next_g;
  logic [VW-1:0] next_b;
  logic [VW-1:0] next_a;
  logic [4*VW-1:0] rec;
  logic rec_tgl;

  // RGGB mosaic: the sensor data is always read as Bayer samples.
  assign hidx = htile[HIDX_W-1:0];
  assign is_red = !row_par && !col_par;
  assign is_blue = row_par && col_par;
  assign is_green = !is_red && !is_blue;
  assign g_diff = (pixel_data > prev_g) ? pixel_data - prev_g : prev_g - pixel_data;

  always_comb begin
    next_r = acc_r[hidx];
    next_g = acc_g[hidx];
    next_b = acc_b[hidx];
    next_a = acc_a[hidx];
    if (is_red) begin
      next_r = sat_add(acc_r[hidx], pixel_data);
    end
    if (is_blue) begin
      next_b = sat_add(acc_b[hidx], pixel_data);
    end
    if (is_green) begin
      next_g = sat_add(acc_g[hidx], pixel_data);
      if (prev_g_ok) begin
        next_a = sat_add(acc_a[hidx], g_diff);
      end
    end
  end

  always_ff @(posedge sensor_pixel_clock or negedge presetn) begin
    if (!presetn) begin
      prev_g <= '0;
      prev_g_ok <= 1'b0;
    end else if (frame_start || line_end || (pix_valid && !in_tile)) begin
      prev_g_ok <= 1'b0;
    end else if (pix_valid && is_green) begin
      prev_g <= pixel_data;
      prev_g_ok <= 1'b1;
    end
  end

  generate
    for (genvar i = 0; i < NUM_H; i++) begin : g_col
      always_ff @(posedge sensor_pixel_clock or negedge presetn) begin
        if (!presetn) begin
          acc_r[i] <= '0;
          acc_g[i] <= '0;
          acc_b[i] <= '0;
          acc_a[i] <= '0;
        end else if (frame_start || (last_px && hidx == i[HIDX_W-1:0])) begin
          acc_r[i] <= '0;
          acc_g[i] <= '0;
          acc_b[i] <= '0;
          acc_a[i] <= '0;
        end else if (pix_valid && in_tile && hidx == i[HIDX_W-1:0]) begin
          acc_r[i] <= next_r;
          acc_g[i] <= next_g;
          acc_b[i] <= next_b;
          acc_a[i] <= next_a;
        end
      end
    end
  endgenerate

  // The record is held until the next tile ends, many pixels later, so the
  // system clock copies it safely once it sees the toggle.
  always_ff @(posedge sensor_pixel_clock or negedge presetn) begin
    if (!presetn) begin
      rec <= '0;
      rec_tgl <= 1'b0;
    end else if (last_px) begin
      rec <= {next_a, next_b, next_g, next_r};
      rec_tgl <= !rec_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Record crossing and FIFO push.

  logic rec_tgl_s;
  logic rec_tgl_q;
  logic [4*VW-1:0] rec_hold;
  bayer_stat_pkg::push_state_t push_state;

  // Relies on the system clock being faster than the pixel clock.
  bayer_stat_sync #(.WIDTH(1)) rec_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(rec_tgl),
    .q(rec_tgl_s)
  );

  assign push_word = (push_state != bayer_stat_pkg::PUSH_IDLE);
  assign fifo_in_valid = push_word;
  assign push_drop = push_word && !fifo_in_ready;
  assign fifo_in_data = (push_state == bayer_stat_pkg::PUSH_LO) ?
                        rec_hold[2*VW-1:0] : rec_hold[4*VW-1:2*VW];

  // A full FIFO drops the word and raises overflow rather than stall the
  // sensor, which cannot be held off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_tgl_q <= 1'b0;
      rec_hold <= '0;
      push_state <= bayer_stat_pkg::PUSH_IDLE;
    end else begin
      rec_tgl_q <= rec_tgl_s;
      case (push_state)
        bayer_stat_pkg::PUSH_IDLE: begin
          if (rec_tgl_s != rec_tgl_q) begin
            rec_hold <= rec;
            push_state <= bayer_stat_pkg::PUSH_LO;
          end
        end
        bayer_stat_pkg::PUSH_LO: push_state <= bayer_stat_pkg::PUSH_HI;
        bayer_stat_pkg::PUSH_HI: push_state <= bayer_stat_pkg::PUSH_IDLE;
        default: push_state <= bayer_stat_pkg::PUSH_IDLE;
      endcase
    end
  end

  bayer_stat_fifo #(.WIDTH(bayer_stat_pkg::WORD_W), .DEPTH(DEPTH)) stat_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(rd_popped),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

endmodule
`default_nettype wire

// *** bayer_stat_pkg.sv ***
// Shared constants and types for the Bayer block statistics design.
package bayer_stat_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Data widths.
  localparam int PIX_W = 8;
  localparam int VAL_W = 16;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_CTRL2 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT_DATA = 8'h08;

  ////////////////////////////////////////////////////////////////////////////
  // Fields of ctrl_reg_second.
  localparam int HSC_LSB = 0;
  localparam int VSC_LSB = 8;
  localparam int SKIP_W = 8;
  localparam int LIVE_VIEW_RES_MODE_LSB = 16;
  localparam int LIVE_VIEW_RES_MODE_W = 3;
  localparam int EN_BIT = 23;
  localparam logic [WORD_W-1:0] CTRL2_RESET = 32'h00000000;
  localparam logic [WORD_W-1:0] CTRL2_MASK = 32'h0087FFFF;
  localparam int CFG_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // Fields of the status register.
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_OVF_BIT = 2;
  localparam int ST_LEVEL_LSB = 8;
  localparam int ST_LEVEL_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Tile grid and geometry.
  localparam int NUM_H_TILES = 8;
  localparam int NUM_V_TILES = 6;
  localparam int POS_W = 9;
  localparam int TILE_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam logic [POS_W-1:0] BLK_MODE0 = 9'h040;
  localparam logic [POS_W-1:0] BLK_MODE1 = 9'h038;
  localparam logic [POS_W-1:0] BLK_MODE2 = 9'h030;
  localparam logic [POS_W-1:0] BLK_MODE3 = 9'h02C;
  localparam logic [POS_W-1:0] BLK_MODE4 = 9'h028;

  typedef enum logic [1:0] {PUSH_IDLE, PUSH_LO, PUSH_HI} push_state_t;

  // Tile edge length in pixels for a live-view mode; unused modes take 40.
  function automatic logic [POS_W-1:0] block_size(input logic [LIVE_VIEW_RES_MODE_W-1:0] mode);
    case (mode)
      3'h0: block_size = BLK_MODE0;
      3'h1: block_size = BLK_MODE1;
      3'h2: block_size = BLK_MODE2;
      3'h3: block_size = BLK_MODE3;
      default: block_size = BLK_MODE4;
    endcase
  endfunction

endpackage

// *** bayer_stat_sync.sv ***
// Two flip-flop level synchroniser, any width.
`timescale 1ns/10ps
`default_nettype none
module bayer_stat_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Level in and synchronised level out.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule
`default_nettype wire

// *** bayer_stat_fifo.sv ***
// Flip-flop FIFO for the 32-bit statistics words.
`timescale 1ns/10ps
`default_nettype none
module bayer_stat_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Occupancy.
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic do_wr;
  logic do_rd;

  assign level = wr_ptr - rd_ptr;
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// *** bayer_stat_properties.sv ***
// Concurrent checks on the register side of the Bayer block statistics block.
`timescale 1ns/10ps
`default_nettype none
module bayer_stat_properties (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave and DMA request.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bayer_stat_pkg::ADDR_W-1:0] paddr,
  input wire logic [bayer_stat_pkg::WORD_W-1:0] pwdata,
  input wire logic [bayer_stat_pkg::WORD_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dma_req
);
  logic [bayer_stat_pkg::WORD_W-1:0] shadow;
  wire logic setup_w = psel && !penable;
  wire logic done_w = psel && penable && pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_phase;
    psel && !penable;
  endsequence
  sequence access_phase;
    psel && penable && pready;
  endsequence
  ////////////////////////////////////////
  // A shadow of the control word lets read-back be judged long after the write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow <= bayer_stat_pkg::CTRL2_RESET;
    end else if (done_w && pwrite && paddr[7:2] == 6'h00) begin
      shadow <= pwdata & bayer_stat_pkg::CTRL2_MASK;
    end
  end
  ////////////////////////////////////////
  ready_after_setup_a: assert property (setup_phase |=> access_phase)
    else $error("no access phase answer after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_cause_a: assert property (pready |-> psel && penable && $past(setup_w))
    else $error("ready without a preceding setup");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  unmapped_err_a: assert property (setup_w && paddr[7:2] > 6'h02 |=> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setup_w && paddr[7:2] <= 6'h02 |=> !pslverr)
    else $error("mapped access refused");
  err_data_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  ctrl_readback_a: assert property (done_w && !pwrite && paddr[7:2] == 6'h00 |-> prdata == shadow)
    else $error("control word read-back wrong");
  dma_empty_a: assert property (done_w && !pwrite && paddr[7:2] == 6'h01 |-> prdata[0] == !dma_req)
    else $error("dma request disagrees with empty flag");
endmodule
bind bayer_block_statistics bayer_stat_properties bayer_stat_properties_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_req(dma_req));
`default_nettype wire

// *** bayer_sensor_model.sv ***
// Behavioural raw Bayer sensor sending one frame per start pulse on a free-running pixel clock.
`timescale 1ns/10ps
`default_nettype none
module bayer_sensor_model #(
  parameter int LINES = 41,
  parameter int PIXELS = 83
) (
  // Sensor pixel bus.
  output logic sensor_pixel_clock,
  output logic vsync,
  output logic hsync,
  output logic [7:0] pixel_data,
  // Control.
  input wire logic start,
  output logic done
);
  // The pixel clock runs free because line sync alone qualifies the pixels.
  initial sensor_pixel_clock = 1'b0;
  always #62.5 sensor_pixel_clock = ~sensor_pixel_clock;
  // Tiles of 40 are split by three skip columns and one skip line filled with 0xFF.
  function automatic logic [7:0] pix(input int x, input int y);
    if (y >= 40 || (x >= 40 && x < 43)) return 8'hFF;
    if (x[0] == y[0]) return y[0] ? 8'h96 : 8'h64;
    return x[1] ? 8'h3C : 8'h28;
  endfunction
  initial begin
    {vsync, hsync, pixel_data, done} = '0;
    forever begin
      @(posedge start);
      done = 1'b0;
      @(negedge sensor_pixel_clock) vsync = 1'b1;
      repeat (2) @(negedge sensor_pixel_clock);
      vsync = 1'b0;
      for (int y = 0; y < LINES; y++) begin
        repeat (3) begin
          @(negedge sensor_pixel_clock) pixel_data = ~pixel_data;
        end
        for (int x = 0; x < PIXELS; x++) begin
          @(negedge sensor_pixel_clock) hsync = 1'b1;
          pixel_data = pix(x, y);
        end
        @(negedge sensor_pixel_clock) hsync = 1'b0;
        pixel_data = ~pixel_data;
      end
      done = 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench: register rows, then one two-tile frame from the sensor model.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic err;
  } row_t;
  localparam int LIMIT = 20000;
  localparam logic [31:0] W0 = {16'(400 * (40 + 60)), 16'(400 * 100)};
  localparam logic [31:0] W1 = {16'(40 * 19 * (60 - 40)), 16'(400 * 150)};
  // Enabled, mode 4 (tile 40), vertical skip 1, horizontal skip 3.
  localparam logic [31:0] CFG = 32'h00840002;
  row_t rows [15] = '{
    '{1'b0, 8'h00, 32'h0, bayer_stat_pkg::CTRL2_RESET, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h00000001, 1'b0},
    '{1'b1, 8'h00, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, bayer_stat_pkg::CTRL2_MASK, 1'b0},
    '{1'b1, 8'h00, 32'h00000500, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h00000500, 1'b0},
    '{1'b1, 8'h00, 32'h00800F0F, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h00800F0F, 1'b0},
    '{1'b1, 8'h00, 32'h00811717, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h00811717, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h0C, 32'h1, 32'h0, 1'b1},
    '{1'b1, 8'h08, 32'hA5A5A5A5, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h00000001, 1'b0}
  };
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [7:0] pixel_data;
  logic pready, pslverr, dma_req, spclk, vsync, hsync, done, er;
  logic start = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 pclk = ~pclk;
  bayer_block_statistics bayer_block_statistics_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_req(dma_req),
    .sensor_pixel_clock(spclk), .vsync(vsync), .hsync(hsync), .pixel_data(pixel_data));
  bayer_sensor_model bayer_sensor_model_i (.sensor_pixel_clock(spclk), .vsync(vsync),
    .hsync(hsync), .pixel_data(pixel_data), .start(start), .done(done));
  ////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // A hang anywhere ends here; the frame needs under 5000 cycles.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata);
      if (!rows[i].wr) check(rd, rows[i].rdata);
      check({31'h0, er}, {31'h0, rows[i].err});
    end
    apb(1'b1, 8'h00, CFG);
    @(posedge pclk) start <= 1'b1;
    wait (done === 1'b1);
    start <= 1'b0;
    repeat (20) @(posedge pclk);
    check({31'h0, dma_req}, 32'h1);
    // Equal words for both tiles show the skip columns never reach a sum.
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 8'h08, 32'h0);
      check(rd, k[0] ? W1 : W0);
    end
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h00000001);
    check({31'h0, dma_req}, 32'h0);
    // A reset in mid-run must bring the control word back to its reset value.
    apb(1'b1, 8'h00, CFG);
    @(posedge pclk) presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(rd, bayer_stat_pkg::CTRL2_RESET);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h00000001);
    wrap_up();
  end
endmodule
`default_nettype wire
